//--- rtl/plr_phy.sv
// Purpose: transceiver register slice with uart pass-through
// Assumes: sources and line state synchronous to pclk
// Notes: cs_reset restores every register except src_prev and lp_prev, which load the current inputs
//
// Local design decision: the APB interface to the registers.
`include "plr_cfg.svh"
`timescale 1ns/10ps
module plr_phy import plr_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    plr_if.phy bus,
    input wire logic id_grounded,
    input wire logic session_ended,
    input wire logic session_ok,
    input wire logic vbus_ok,
    input wire logic host_detached,
    input wire logic line_state_bit1,
    input wire logic line_state_bit0,
    input wire logic low_power,
    input wire logic dp_rx,
    output logic dm_tx,
    output logic dm_tx_oe,
    output logic uart_active
);
    // ---------------------------------------------------
    // state
    // ---------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic [4:0] event_latch;
        logic [4:0] src_prev;
        logic [4:0] rise_event_enable;
        logic [4:0] fall_event_enable;
        logic [7:0] scratch_byte;
        logic [7:0] interface_control;
        logic [7:0] uart_passthru_ctrl;
        logic lp_prev;
        logic dm_tx;
        logic dm_tx_oe;
        logic data1;
        logic data1_oe;
        logic uart_active;
    } plr_phy_st_t;

    plr_phy_st_t st_ff;
    plr_phy_st_t nxt_st;

    // ---------------------------------------------------
    // helpers
    // ---------------------------------------------------
    function automatic plr_acc_t acc_kind(input logic [5:0] a,
            input logic [5:0] base);
        logic [5:0] d;
        d = a - base;
        case (d)
            `PLR_OFS_WR: acc_kind = PLR_WR;
            `PLR_OFS_SET: acc_kind = PLR_SET;
            `PLR_OFS_CLR: acc_kind = PLR_CLR;
            default: acc_kind = PLR_NONE;
        endcase
    endfunction : acc_kind

    function automatic logic [7:0] apply_acc(input logic [7:0] old,
            input plr_acc_t k, input logic [7:0] wd);
        case (k)
            PLR_WR: apply_acc = wd;
            PLR_SET: apply_acc = old | wd;
            PLR_CLR: apply_acc = old & ~wd;
            default: apply_acc = old;
        endcase
    endfunction : apply_acc

    function automatic logic in_range(input logic [5:0] a,
            input logic [5:0] base);
        in_range = (a >= base) && (a <= base + `PLR_OFS_CLR);
    endfunction : in_range

    // ---------------------------------------------------
    // inputs and decode
    // ---------------------------------------------------
    logic [4:0] src;
    logic [4:0] events;
    logic take;
    logic mode_on;
    logic [7:0] rd;

    assign src = {id_grounded, session_ended, session_ok, vbus_ok,
        host_detached};

    // ---------------------------------------------------
    // next state
    // ---------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.src_prev = src;
        nxt_st.lp_prev = low_power;
        nxt_st.ack = 1'b0;
        events = (src & ~st_ff.src_prev & st_ff.rise_event_enable)
            | (~src & st_ff.src_prev & st_ff.fall_event_enable);
        mode_on = st_ff.interface_control[`PLR_ICTL_MODE];
        take = bus.req && !st_ff.ack && !st_ff.uart_active;
        rd = 8'h00;
        // ---------------------------------------------------
        // read decode
        // ---------------------------------------------------
        if (take) begin
            if (bus.addr == `PLR_A_ICTL) begin
                rd = st_ff.interface_control;
            end else if (in_range(bus.addr, `PLR_A_RISE)) begin
                rd = {3'h0, st_ff.rise_event_enable};
            end else if (in_range(bus.addr, `PLR_A_FALL)) begin
                rd = {3'h0, st_ff.fall_event_enable};
            end else if (bus.addr == `PLR_A_STAT) begin
                rd = {3'h0, src};
            end else if (bus.addr == `PLR_A_LATCH) begin
                rd = {3'h0, st_ff.event_latch};
            end else if (bus.addr == `PLR_A_DEBUG) begin
                rd = {6'h00, line_state_bit1, line_state_bit0};
            end else if (in_range(bus.addr, `PLR_A_SCR)) begin
                rd = st_ff.scratch_byte;
            end else if (in_range(bus.addr, `PLR_A_UART)) begin
                rd = st_ff.uart_passthru_ctrl;
            end
            nxt_st.ack = 1'b1;
            nxt_st.rdata = rd;
        end
        // ---------------------------------------------------
        // register writes
        // ---------------------------------------------------
        if (take && bus.we) begin
            if (bus.addr == `PLR_A_ICTL) begin
                nxt_st.interface_control = bus.wdata;
            end
            nxt_st.rise_event_enable = 5'(apply_acc(
                {3'h0, st_ff.rise_event_enable},
                acc_kind(bus.addr, `PLR_A_RISE), {3'h0, bus.wdata[4:0]}));
            nxt_st.fall_event_enable = 5'(apply_acc(
                {3'h0, st_ff.fall_event_enable},
                acc_kind(bus.addr, `PLR_A_FALL), {3'h0, bus.wdata[4:0]}));
            nxt_st.scratch_byte = apply_acc(st_ff.scratch_byte,
                acc_kind(bus.addr, `PLR_A_SCR), bus.wdata);
            nxt_st.uart_passthru_ctrl = apply_acc(st_ff.uart_passthru_ctrl,
                acc_kind(bus.addr, `PLR_A_UART), bus.wdata);
        end
        // ---------------------------------------------------
        // event latch
        // ---------------------------------------------------
        // latch clears on read or low-power entry, new events win
        if ((take && !bus.we && bus.addr == `PLR_A_LATCH)
                || (low_power && !st_ff.lp_prev)) begin
            nxt_st.event_latch = events;
        end else begin
            nxt_st.event_latch = st_ff.event_latch | events;
        end
        // ---------------------------------------------------
        // uart routing
        // ---------------------------------------------------
        // pass-through entered once mode set and a route enabled
        nxt_st.uart_active = mode_on && (st_ff.uart_passthru_ctrl[
            `PLR_UART_RXD] || st_ff.uart_passthru_ctrl[`PLR_UART_TXD]);
        nxt_st.dm_tx = bus.data0;
        nxt_st.dm_tx_oe = mode_on
            && st_ff.uart_passthru_ctrl[`PLR_UART_TXD];
        nxt_st.data1 = dp_rx;
        nxt_st.data1_oe = mode_on
            && st_ff.uart_passthru_ctrl[`PLR_UART_RXD];
        // ---------------------------------------------------
        // mode exit and soft reset
        // ---------------------------------------------------
        if (bus.stp && st_ff.uart_active) begin
            nxt_st.interface_control[`PLR_ICTL_MODE] = 1'b0;
            nxt_st.uart_passthru_ctrl[`PLR_UART_RXD] = 1'b0;
            nxt_st.uart_passthru_ctrl[`PLR_UART_TXD] = 1'b0;
            nxt_st.uart_active = 1'b0;
            nxt_st.dm_tx_oe = 1'b0;
            nxt_st.data1_oe = 1'b0;
        end
        if (bus.cs_reset) begin
            nxt_st = '0;
            nxt_st.src_prev = src;
            nxt_st.lp_prev = low_power;
            nxt_st.rise_event_enable = `PLR_EN_RST;
            nxt_st.fall_event_enable = `PLR_EN_RST;
        end
    end

    // ---------------------------------------------------
    // registers
    // ---------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.rise_event_enable <= `PLR_EN_RST;
            st_ff.fall_event_enable <= `PLR_EN_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ---------------------------------------------------
    // outputs
    // ---------------------------------------------------
    assign bus.ack = st_ff.ack;
    assign bus.rdata = st_ff.rdata;
    assign bus.data1 = st_ff.data1;
    assign bus.data1_oe = st_ff.data1_oe;
    assign dm_tx = st_ff.dm_tx;
    assign dm_tx_oe = st_ff.dm_tx_oe;
    assign uart_active = st_ff.uart_active;
endmodule : plr_phy

//--- rtl/plr_cfg.svh
// Purpose: addresses, fields, reset values
// Assumes: byte-wide register file, 6-bit address
// Notes: host register offsets are byte addresses
`ifndef PLR_CFG_SVH
`define PLR_CFG_SVH
`define PLR_A_ICTL 6'h07
`define PLR_A_RISE 6'h0d
`define PLR_A_FALL 6'h10
`define PLR_A_STAT 6'h13
`define PLR_A_LATCH 6'h14
`define PLR_A_DEBUG 6'h15
`define PLR_A_SCR 6'h16
`define PLR_A_UART 6'h19
`define PLR_OFS_WR 6'h00
`define PLR_OFS_SET 6'h01
`define PLR_OFS_CLR 6'h02
`define PLR_EN_RST 5'h1f
`define PLR_ICTL_MODE 2
`define PLR_UART_RXD 3
`define PLR_UART_TXD 2
`define PLR_UART_LEGAL 8'h0c
`define PLR_H_CMD 8'h00
`define PLR_H_STAT 8'h04
`define PLR_H_EXIT 8'h08
`define PLR_H_TX 8'h0c
`define PLR_H_IRQ 8'h10
`define PLR_H_MASK 8'h14
`define PLR_CMD_WE 16
`define PLR_IRQ_DONE 0
`define PLR_IRQ_REFUSED 1
`define PLR_IRQ_EXIT 2
`endif

//--- rtl/plr_pkg.sv
// Purpose: shared types of both ends
// Assumes: plr_cfg.svh constants
// Notes: none
package plr_pkg;
    typedef enum logic [1:0] {PLR_WR = 2'b00, PLR_SET = 2'b01,
        PLR_CLR = 2'b11, PLR_NONE = 2'b10} plr_acc_t;
    typedef enum logic [1:0] {PLR_IDLE = 2'b00, PLR_REQ = 2'b01,
        PLR_UART = 2'b11, PLR_SPARE = 2'b10} plr_lstate_t;
endpackage : plr_pkg

//--- rtl/plr_if.sv
// Purpose: register path and uart pins between link and phy
// Assumes: one clock, pclk
// Notes: req held until ack
`timescale 1ns/10ps
interface plr_if;
    logic req;
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    logic stp;
    logic cs_reset;
    logic data0;
    logic data0_oe;
    logic data1;
    logic data1_oe;
    modport phy (input req, we, addr, wdata, stp, cs_reset, data0,
        data0_oe, output ack, rdata, data1, data1_oe);
    modport link (output req, we, addr, wdata, stp, cs_reset, data0,
        data0_oe, input ack, rdata, data1, data1_oe);
endinterface : plr_if

//--- rtl/plr_link.sv
// Purpose: link end, apb slave issuing phy register accesses
// Assumes: phy acks each request
// Notes: no phy requests while pass-through is on
`include "plr_cfg.svh"
`timescale 1ns/10ps
module plr_link import plr_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    plr_if.link bus,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    // ---------------------------------------------------
    // state
    // ---------------------------------------------------
    typedef struct packed {
        plr_lstate_t st;
        logic req;
        logic we;
        logic [5:0] addr;
        logic [7:0] wdata;
        logic [7:0] last_rd;
        logic mode_seen;
        logic stp;
        logic cs_reset;
        logic data0;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } plr_link_st_t;

    plr_link_st_t st_ff;
    plr_link_st_t nxt_st;
    logic setup;
    logic [5:0] ca;
    logic [7:0] cd;
    logic [2:0] ev;

    always_comb begin
        nxt_st = st_ff;
        setup = psel && !penable;
        ca = pwdata[13:8];
        cd = pwdata[7:0];
        ev = 3'h0;
        nxt_st.pready = setup;
        nxt_st.pslverr = 1'b0;
        nxt_st.stp = 1'b0;
        nxt_st.cs_reset = 1'b0;
        // ---------------------------------------------------
        // phy request sequencing
        // ---------------------------------------------------
        if (st_ff.st == PLR_REQ && bus.ack) begin
            nxt_st.req = 1'b0;
            nxt_st.last_rd = bus.rdata;
            ev[`PLR_IRQ_DONE] = 1'b1;
            nxt_st.st = PLR_IDLE;
            if (st_ff.we && st_ff.addr == `PLR_A_ICTL) begin
                nxt_st.mode_seen = st_ff.wdata[`PLR_ICTL_MODE];
            end
            if (st_ff.we && st_ff.mode_seen && st_ff.addr >= `PLR_A_UART
                    && st_ff.addr <= `PLR_A_UART + `PLR_OFS_CLR
                    && (st_ff.wdata & `PLR_UART_LEGAL) != 8'h00
                    && st_ff.addr != `PLR_A_UART + `PLR_OFS_CLR) begin
                nxt_st.st = PLR_UART;
            end
        end
        if (setup && pwrite) begin
            case (paddr)
                `PLR_H_CMD: begin
                    if (st_ff.st == PLR_IDLE) begin
                        nxt_st.st = PLR_REQ;
                        nxt_st.req = 1'b1;
                        nxt_st.we = pwdata[`PLR_CMD_WE];
                        nxt_st.addr = ca;
                        nxt_st.wdata = cd;
                        if (ca >= `PLR_A_UART
                                && ca <= `PLR_A_UART + `PLR_OFS_CLR) begin
                            nxt_st.wdata = cd & `PLR_UART_LEGAL;
                            if (!st_ff.mode_seen) begin
                                nxt_st.wdata = 8'h00;
                            end
                        end
                    end else begin
                        ev[`PLR_IRQ_REFUSED] = 1'b1;
                    end
                end
                `PLR_H_EXIT: begin
                    nxt_st.stp = pwdata[0];
                    nxt_st.cs_reset = pwdata[1];
                    if (pwdata[1]) begin
                        nxt_st.mode_seen = 1'b0;
                    end
                    if ((pwdata[0] || pwdata[1])
                            && st_ff.st == PLR_UART) begin
                        nxt_st.st = PLR_IDLE;
                        nxt_st.mode_seen = 1'b0;
                        ev[`PLR_IRQ_EXIT] = 1'b1;
                    end
                end
                `PLR_H_TX: nxt_st.data0 = pwdata[0];
                `PLR_H_MASK: nxt_st.irq_mask = pwdata[2:0];
                `PLR_H_STAT, `PLR_H_IRQ: ;
                default: nxt_st.pslverr = 1'b1;
            endcase
        end
        // ---------------------------------------------------
        // read data and sticky events
        // ---------------------------------------------------
        nxt_st.irq_stat = st_ff.irq_stat | ev;
        if (setup && !pwrite) begin
            case (paddr)
                `PLR_H_STAT: nxt_st.prdata = {16'h0000, st_ff.last_rd,
                    4'h0, bus.data1, st_ff.mode_seen, st_ff.st};
                `PLR_H_TX: nxt_st.prdata = {31'h0, st_ff.data0};
                `PLR_H_IRQ: begin
                    nxt_st.prdata = {29'h0, st_ff.irq_stat};
                    nxt_st.irq_stat = ev;
                end
                `PLR_H_MASK: nxt_st.prdata = {29'h0, st_ff.irq_mask};
                `PLR_H_CMD, `PLR_H_EXIT: nxt_st.prdata = 32'h0;
                default: begin
                    nxt_st.prdata = 32'h0;
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus.req = st_ff.req;
    assign bus.we = st_ff.we;
    assign bus.addr = st_ff.addr;
    assign bus.wdata = st_ff.wdata;
    assign bus.stp = st_ff.stp;
    assign bus.cs_reset = st_ff.cs_reset;
    assign bus.data0 = st_ff.data0;
    assign bus.data0_oe = (st_ff.st == PLR_UART);
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign irq = st_ff.irq;
endmodule : plr_link

//--- sim/plr_checker.sv
// Purpose: checks on the link to phy interface
// Assumes: one clock domain, pclk
// Notes: sees interface signals only
`timescale 1ns/10ps
module plr_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic we,
    input wire logic [5:0] addr,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic stp,
    input wire logic cs_reset,
    input wire logic data0_oe,
    input wire logic data1_oe
);
    // ---------
    // properties
    // ---------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_ack_src;
        ack |-> $past(req);
    endproperty
    a_ack_src: assert property (p_ack_src)
        else $error("ack without request");
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_req_ack;
        $rose(req) |=> ack;
    endproperty
    a_req_ack: assert property (p_req_ack)
        else $error("request not answered");
    property p_quiet;
        data0_oe && !req |=> !req;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("request in uart mode");
    property p_latch_rsv;
        ack && !we && addr == 6'h14 |-> rdata[7:5] == 3'h0;
    endproperty
    a_latch_rsv: assert property (p_latch_rsv)
        else $error("latch reserved bits set");
    property p_dbg_rsv;
        ack && !we && addr == 6'h15 |-> rdata[7:2] == 6'h00;
    endproperty
    a_dbg_rsv: assert property (p_dbg_rsv)
        else $error("debug reserved bits set");
    property p_uart_rsv;
        ack && !we && addr >= 6'h19 && addr <= 6'h1b
            |-> rdata[7:4] == 4'h0 && rdata[1:0] == 2'h0;
    endproperty
    a_uart_rsv: assert property (p_uart_rsv)
        else $error("uart control reserved bits set");
    property p_stp_exit;
        stp |-> ##[1:4] !data1_oe;
    endproperty
    a_stp_exit: assert property (p_stp_exit)
        else $error("stp did not end rx route");
    property p_rst_exit;
        cs_reset |-> ##[1:4] !data1_oe;
    endproperty
    a_rst_exit: assert property (p_rst_exit)
        else $error("chip reset did not end rx route");
endmodule : plr_checker

//--- sim/plr_bench.sv
// Purpose: apb driven test of link and phy together
// Assumes: zero wait apb, one clock
// Notes: phy reached through link cmd register
`timescale 1ns/10ps
module plr_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [4:0] src = 5'h00;
    logic [1:0] ls = 2'h0;
    logic low_power = 1'b0;
    logic dp_rx = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, dm_tx, dm_tx_oe, uart_active, last_err;
    int error_cnt = 0;
    int check_count = 0;
    always #2.5 pclk = ~pclk;
    plr_if plr_if_i ();
    plr_phy plr_phy_i (.pclk(pclk), .presetn(presetn), .bus(plr_if_i),
        .id_grounded(src[4]), .session_ended(src[3]),
        .session_ok(src[2]), .vbus_ok(src[1]), .host_detached(src[0]),
        .line_state_bit1(ls[1]), .line_state_bit0(ls[0]),
        .low_power(low_power), .dp_rx(dp_rx), .dm_tx(dm_tx),
        .dm_tx_oe(dm_tx_oe), .uart_active(uart_active));
    plr_link plr_link_i (.pclk(pclk), .presetn(presetn), .bus(plr_if_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    plr_checker plr_checker_i (.pclk(pclk), .presetn(presetn),
        .req(plr_if_i.req), .we(plr_if_i.we), .addr(plr_if_i.addr),
        .ack(plr_if_i.ack), .rdata(plr_if_i.rdata), .stp(plr_if_i.stp),
        .cs_reset(plr_if_i.cs_reset), .data0_oe(plr_if_i.data0_oe),
        .data1_oe(plr_if_i.data1_oe));
    // ---------
    // tasks
    // ---------
    task automatic finish_test();
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [31:0] e,
            input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic phy(input logic w, input logic [5:0] a,
            input logic [7:0] d, output logic [7:0] r);
        logic [31:0] s;
        int n;
        apb(1'b1, 8'h00, {15'h0, w, 2'h0, a, d}, s);
        n = 0;
        do begin
            apb(1'b0, 8'h04, 32'h0, s);
            n++;
        end while (s[1:0] == 2'b01 && n < 20);
        if (n >= 20) begin
            error_cnt++;
        end
        r = s[15:8];
    endtask : phy
    task automatic pwr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] r;
        phy(1'b1, a, d, r);
    endtask : pwr
    task automatic prd(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] r;
        phy(1'b0, a, 8'h00, r);
        chk($sformatf("reg %h", a), e, r);
    endtask : prd
    task automatic settle();
        repeat (3) @(negedge pclk);
    endtask : settle
    // ---------
    // tests
    // ---------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        prd(6'h14, 8'h00);
        prd(6'h16, 8'h00);
        prd(6'h19, 8'h00);
        chk("irq", 32'h0, irq);
        ls <= 2'h2;
        prd(6'h15, 8'h02);
        ls <= 2'h1;
        prd(6'h15, 8'h01);
        pwr(6'h16, 8'ha5);
        pwr(6'h17, 8'h50);
        prd(6'h16, 8'hf5);
        pwr(6'h18, 8'h81);
        prd(6'h18, 8'h74);
        prd(6'h14, 8'h00);
        chk("uart_active", 32'h0, uart_active);
        src <= 5'h10;
        prd(6'h14, 8'h10);
        prd(6'h14, 8'h00);
        pwr(6'h0f, 8'h04);
        prd(6'h0e, 8'h1b);
        src <= 5'h16;
        prd(6'h14, 8'h02);
        pwr(6'h10, 8'h10);
        src <= 5'h00;
        prd(6'h14, 8'h10);
        src <= 5'h08;
        repeat (4) @(posedge pclk);
        low_power <= 1'b1;
        @(posedge pclk);
        low_power <= 1'b0;
        prd(6'h14, 8'h00);
        apb(1'b0, 8'h40, 32'h0, rd);
        chk("pslverr", 32'h1, last_err);
        apb(1'b1, 8'h14, 32'h1, rd);
        settle();
        chk("irq", 32'h1, irq);
        apb(1'b0, 8'h10, 32'h0, rd);
        chk("irq_stat", 32'h1, rd[0]);
        settle();
        chk("irq", 32'h0, irq);
        apb(1'b1, 8'h14, 32'h4, rd);
        apb(1'b0, 8'h14, 32'h0, rd);
        chk("irq_mask", 32'h4, rd);
        pwr(6'h19, 8'h0c);
        settle();
        chk("uart_active", 32'h0, uart_active);
        pwr(6'h07, 8'h04);
        pwr(6'h1a, 8'h0c);
        settle();
        chk("uart_active", 32'h1, uart_active);
        apb(1'b1, 8'h0c, 32'h1, rd);
        dp_rx <= 1'b1;
        settle();
        chk("dm_tx", 32'h3, {dm_tx_oe, dm_tx});
        apb(1'b0, 8'h04, 32'h0, rd);
        chk("data1", 32'h1, rd[3]);
        chk("link_state", 32'h7, rd[2:0]);
        apb(1'b1, 8'h0c, 32'h0, rd);
        dp_rx <= 1'b0;
        settle();
        chk("dm_tx", 32'h2, {dm_tx_oe, dm_tx});
        apb(1'b0, 8'h04, 32'h0, rd);
        chk("data1", 32'h0, rd[3]);
        apb(1'b1, 8'h08, 32'h1, rd);
        settle();
        chk("uart_active", 32'h0, uart_active);
        chk("irq", 32'h1, irq);
        apb(1'b0, 8'h10, 32'h0, rd);
        chk("irq_stat", 32'h1, rd[2]);
        prd(6'h19, 8'h00);
        pwr(6'h16, 8'h3c);
        pwr(6'h07, 8'h04);
        pwr(6'h19, 8'hf3);
        prd(6'h19, 8'h00);
        pwr(6'h19, 8'h0c);
        settle();
        chk("uart_active", 32'h1, uart_active);
        apb(1'b1, 8'h00, 32'h000116ff, rd);
        apb(1'b0, 8'h10, 32'h0, rd);
        chk("irq_refused", 32'h1, rd[1]);
        apb(1'b1, 8'h08, 32'h2, rd);
        settle();
        chk("uart_active", 32'h0, uart_active);
        prd(6'h16, 8'h00);
        prd(6'h19, 8'h00);
        finish_test();
    end
    initial begin
        #50000;
        error_cnt++;
        finish_test();
    end
endmodule : plr_bench
